// ==== include/ictc_map.svh ====
// Constants of the coil timing capture sequencer
// ----------------------------------------------------------------------
// What this block does
// - Zero calibration averages each of six probe pairs over eight samples.
// - Successful calibration offsets go to nonvolatile memory, then correct capacitance.
// - Inductance runs only for resistive parts below 2100 ohms.
// - Sixteen-bit timing counter starts as coil current is switched on.
// - Comparator crossing of the internal reference latches the counter.
// - Every counter rollover increments a separate overflow tally.
// - Counter halts once the capture event has happened.
// - Elapsed time comes from latched count plus overflow tally.
// - After timing, positive terminal goes to ground until no current remains.
// - Coils below 24 ohms are measured without the 680 ohm resistor.
// - Results with the sense resistor have 0.1 mH resolution.
// - Results without the sense resistor have 0.01 mH resolution.
// - Six counts are subtracted when measuring without sense resistor.
// - Seven or eight counts are subtracted when measuring with it.
// - Measurement is repeated with counter start delayed after switch-on.
// - Delayed repeats always use the 680 ohm sense resistor.
// - Each coil is measured with current in both directions.
// - Keep the larger result per direction, report the smaller direction.
// - Logarithm term comes from a built-in lookup table.
// ----------------------------------------------------------------------
`ifndef ICTC_MAP_SVH
`define ICTC_MAP_SVH

`define CLK_NS 50
`define CNT_W 16
`define CNT_MAX 16'hffff
`define RES_LIMIT_OHM 12'd2100
`define L_NOSENSE_OHM 12'd24
`define PORT_OHM 13'd19
`define SENSE_OHM 13'd680
`define ZERO_FINE 32'd6
`define ZERO_SENSE_DEF 7
`define L_DELAY_NS 5000
`define L_DELAY_CYC 16'((`L_DELAY_NS + `CLK_NS - 1) / `CLK_NS)
`define LOG_Q 256
`define L_FINE_NS 10000
`define L_COARSE_NS 100000
`define L_DIV_FINE 64'(`LOG_Q * `L_FINE_NS / `CLK_NS)
`define L_DIV_COARSE 64'(`LOG_Q * `L_COARSE_NS / `CLK_NS)
`define COARSE_TO_FINE 64'd10
`define CAL_COMBOS 6
`define CAL_LAST 3'd5
`define CAL_REPS 4'd8
`define CAL_SHIFT 3
`define CAL_MAX_DEF 16'h0190

`endif

// ==== include/ictc_pkg.sv ====
// Types of the coil timing capture sequencer
package ictc_pkg;

  typedef enum logic [2:0] {ST_IDLE, ST_DELAY, ST_RUN, ST_DISCH, ST_CAL, ST_NVM} ictc_state_type;

  typedef struct packed {
    logic pos_high;
    logic pos_low;
    logic sense_in;
    logic reverse;
  } ictc_coil_type;

  typedef struct packed {
    logic valid;
    logic skipped;
    logic fine;
    logic [31:0] value;
  } ictc_result_type;

  typedef struct packed {
    logic valid;
    logic [2:0] combo;
    logic [15:0] value;
  } ictc_cap_type;

  typedef struct packed {
    ictc_state_type st;
    ictc_coil_type coil;
    logic [15:0] cnt;
    logic [15:0] ovf;
    logic [15:0] dly;
    logic dir;
    logic att;
    logic [1:0][31:0] best;
    logic [1:0] best_fine;
    ictc_result_type res;
    logic busy;
    logic [5:0][18:0] sums;
    logic [5:0][3:0] seen;
    logic [5:0][15:0] offs;
    ictc_cap_type cap_out;
    logic nvm_we;
    logic [2:0] nvm_addr;
    logic [15:0] nvm_data;
    logic cal_ok;
    logic [2:0] widx;
  } ictc_regs_type;

endpackage

// ==== hw/ictc_core.sv ====
// Coil timing capture sequencer with capacitance zero calibration
`timescale 1ns/10ps
`include "ictc_map.svh"

module ictc_core
  import ictc_pkg::*;
#(
  parameter int ZERO_SENSE = `ZERO_SENSE_DEF,
  parameter logic [15:0] CAL_MAX = `CAL_MAX_DEF
) (
  // Clock and reset
  input wire logic CLOCK,
  input wire logic SRST,
  // Requests and part data
  input wire logic START,
  input wire logic CAL_START,
  input wire logic PART_IS_RES,
  input wire logic [11:0] PART_RES,
  input wire logic [3:0] LOG_INDEX,
  // Analog front end
  input wire logic CMP_ABOVE,
  input wire logic NO_CUR_A,
  input wire logic NO_CUR_B,
  // Capacitance samples
  input wire ictc_cap_type CAP_IN,
  // Coil drive
  output ictc_coil_type COIL,
  // Results
  output ictc_result_type RESULT,
  output logic BUSY,
  output ictc_cap_type CAP_OUT,
  output logic CAL_OK,
  // Nonvolatile store
  output logic NVM_WE,
  output logic [2:0] NVM_ADDR,
  output logic [15:0] NVM_DATA
);

  // ----------------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------------
  if (ZERO_SENSE < 7 || ZERO_SENSE > 8) begin : g_bad_zero
    $error("ZERO_SENSE must be 7 or 8");
  end
  if (CAL_MAX == 16'h0) begin : g_bad_cal
    $error("CAL_MAX must be above zero");
  end
  // Tally and count are joined as two 16-bit halves
  if (`CNT_W != 16) begin : g_bad_width
    $error("counter width must be 16");
  end

  // ----------------------------------------------------------------------
  // Log table
  // ----------------------------------------------------------------------
  // Q8 of -1/ln(1-x), x at the centre of each sixteenth of Uref/Umax
  function automatic logic [15:0] log_term(input logic [3:0] idx);
    case (idx)
      4'h0: log_term = 16'h1f80;
      4'h1: log_term = 16'h0a29;
      4'h2: log_term = 16'h05e3;
      4'h3: log_term = 16'h040d;
      4'h4: log_term = 16'h0307;
      4'h5: log_term = 16'h0260;
      4'h6: log_term = 16'h01eb;
      4'h7: log_term = 16'h0195;
      4'h8: log_term = 16'h0152;
      4'h9: log_term = 16'h011c;
      4'ha: log_term = 16'h00f0;
      4'hb: log_term = 16'h00ca;
      4'hc: log_term = 16'h00a8;
      4'hd: log_term = 16'h008a;
      4'he: log_term = 16'h006c;
      default: log_term = 16'h004a;
    endcase
  endfunction

  // ----------------------------------------------------------------------
  // Arithmetic
  // ----------------------------------------------------------------------
  // Difference floored at zero, shared by timing and capacitance paths
  function automatic logic [31:0] sub_floor(input logic [31:0] a, input logic [31:0] b);
    sub_floor = (a > b) ? a - b : 32'h0;
  endfunction

  // Tally and held count joined, zero offset removed, floored at zero
  function automatic logic [31:0] elapsed(input logic [15:0] ovf, input logic [15:0] cnt,
                                          input logic sense);
    logic [31:0] raw;
    logic [31:0] off;
    raw = {ovf, cnt};
    off = sense ? 32'(ZERO_SENSE) : `ZERO_FINE;
    elapsed = sub_floor(raw, off);
  endfunction

  // Inductance in 0.01 mH units; coarse runs are truncated to 0.1 mH
  function automatic logic [31:0] induct(input logic [31:0] t, input logic [11:0] ohm,
                                         input logic sense, input logic [3:0] idx);
    logic [12:0] rges;
    logic [63:0] prod;
    logic [63:0] v;
    rges = 13'(ohm) + `PORT_OHM + (sense ? `SENSE_OHM : 13'h0);
    prod = 64'(t) * 64'(rges) * 64'(log_term(idx));
    if (sense) begin
      v = (prod / `L_DIV_COARSE) * `COARSE_TO_FINE;
    end else begin
      v = prod / `L_DIV_FINE;
    end
    induct = (v > 64'h0000_0000_ffff_ffff) ? 32'hffff_ffff : v[31:0];
  endfunction

  // Switch current on; counter starts now or after the delay
  function automatic ictc_regs_type launch(input ictc_regs_type r, input logic [11:0] ohm);
    ictc_regs_type q;
    q = r;
    q.coil.pos_high = 1'b1;
    q.coil.pos_low = 1'b0;
    q.coil.reverse = r.dir;
    q.coil.sense_in = r.att | (ohm >= `L_NOSENSE_OHM);
    q.cnt = 16'h0;
    q.ovf = 16'h0;
    q.dly = `L_DELAY_CYC;
    q.st = r.att ? ST_DELAY : ST_RUN;
    return q;
  endfunction

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  ictc_regs_type r;
  ictc_regs_type next_r;
  logic [5:0][15:0] avg;
  logic all_seen;
  logic cal_good;
  logic [31:0] t_el;
  logic [31:0] val;

  // ----------------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------------
  always_comb begin
    next_r = r;
    next_r.res.valid = 1'b0;
    next_r.nvm_we = 1'b0;
    next_r.cap_out.valid = 1'b0;
    all_seen = 1'b1;
    cal_good = 1'b1;
    for (int i = 0; i < `CAL_COMBOS; i++) begin
      avg[i] = r.sums[i][18:`CAL_SHIFT];
      all_seen = all_seen & (r.seen[i] == `CAL_REPS);
      cal_good = cal_good & (avg[i] <= CAL_MAX);
    end
    // Held count read before the update, so discharge sees the captured value
    t_el = elapsed(r.ovf, r.cnt, r.coil.sense_in);
    val = induct(t_el, PART_RES, r.coil.sense_in, LOG_INDEX);

    // ------------------------------------------------------------------
    // Capacitance correction
    // ------------------------------------------------------------------
    // Offsets corrected on every sample of combinations 0 to 5 outside calibration
    if (CAP_IN.valid && r.st != ST_CAL && CAP_IN.combo <= `CAL_LAST) begin
      next_r.cap_out.valid = 1'b1;
      next_r.cap_out.combo = CAP_IN.combo;
      next_r.cap_out.value = 16'(sub_floor(32'(CAP_IN.value),
                                           32'(r.offs[CAP_IN.combo])));
    end

    // ------------------------------------------------------------------
    // Measurement and calibration steps
    // ------------------------------------------------------------------
    case (r.st)
      ST_IDLE: begin
        // START wins over CAL_START in the same cycle
        next_r.busy = 1'b0;
        next_r.coil = '0;
        if (START) begin
          if (PART_IS_RES && PART_RES < `RES_LIMIT_OHM) begin
            next_r.busy = 1'b1;
            next_r.dir = 1'b0;
            next_r.att = 1'b0;
            next_r.best = '0;
            next_r.best_fine = '0;
            next_r = launch(next_r, PART_RES);
          end else begin
            next_r.res = '0;
            next_r.res.valid = 1'b1;
            next_r.res.skipped = 1'b1;
          end
        end else if (CAL_START) begin
          next_r.busy = 1'b1;
          next_r.sums = '0;
          next_r.seen = '0;
          next_r.st = ST_CAL;
        end
      end
      ST_DELAY: begin
        // Lets the parasitic capacitance spike pass before timing
        next_r.dly = r.dly - 16'h1;
        if (r.dly <= 16'h1) begin
          next_r.st = ST_RUN;
        end
      end
      ST_RUN: begin
        if (CMP_ABOVE || (r.ovf == `CNT_MAX && r.cnt == `CNT_MAX)) begin
          // Count held where it stood; tally saturation ends runaway timing
          next_r.st = ST_DISCH;
          next_r.coil.pos_high = 1'b0;
          next_r.coil.pos_low = 1'b1;
        end else begin
          next_r.cnt = r.cnt + 16'h1;
          if (r.cnt == `CNT_MAX) begin
            next_r.ovf = r.ovf + 16'h1;
          end
        end
      end
      ST_DISCH: begin
        // One quiet terminal can still hide current, so both must settle
        if (NO_CUR_A && NO_CUR_B) begin
          next_r.coil = '0;
          if (val > r.best[r.dir]) begin
            next_r.best[r.dir] = val;
            next_r.best_fine[r.dir] = ~r.coil.sense_in;
          end
          if (!r.att) begin
            next_r.att = 1'b1;
            next_r = launch(next_r, PART_RES);
          end else if (!r.dir) begin
            next_r.dir = 1'b1;
            next_r.att = 1'b0;
            next_r = launch(next_r, PART_RES);
          end else begin
            next_r.st = ST_IDLE;
            next_r.busy = 1'b0;
            next_r.res.valid = 1'b1;
            next_r.res.skipped = 1'b0;
            if (next_r.best[1] < next_r.best[0]) begin
              next_r.res.value = next_r.best[1];
              next_r.res.fine = next_r.best_fine[1];
            end else begin
              next_r.res.value = next_r.best[0];
              next_r.res.fine = next_r.best_fine[0];
            end
          end
        end
      end
      ST_CAL: begin
        // Extra samples of a finished combination are dropped
        if (all_seen) begin
          next_r.cal_ok = cal_good;
          if (cal_good) begin
            next_r.offs = avg;
            next_r.widx = 3'h0;
            next_r.st = ST_NVM;
          end else begin
            next_r.busy = 1'b0;
            next_r.st = ST_IDLE;
          end
        end else if (CAP_IN.valid && CAP_IN.combo <= `CAL_LAST
                     && r.seen[CAP_IN.combo] != `CAL_REPS) begin
          next_r.sums[CAP_IN.combo] = r.sums[CAP_IN.combo] + 19'(CAP_IN.value);
          next_r.seen[CAP_IN.combo] = r.seen[CAP_IN.combo] + 4'h1;
        end
      end
      ST_NVM: begin
        // One word per cycle; the store must take back-to-back writes
        next_r.nvm_we = 1'b1;
        next_r.nvm_addr = r.widx;
        next_r.nvm_data = r.offs[r.widx];
        next_r.widx = r.widx + 3'h1;
        if (r.widx == `CAL_LAST) begin
          next_r.busy = 1'b0;
          next_r.st = ST_IDLE;
        end
      end
      default: begin
        next_r.st = ST_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  // Straight from the state register, no logic after the flops
  assign COIL = r.coil;
  assign RESULT = r.res;
  assign BUSY = r.busy;
  assign CAP_OUT = r.cap_out;
  assign CAL_OK = r.cal_ok;
  assign NVM_WE = r.nvm_we;
  assign NVM_ADDR = r.nvm_addr;
  assign NVM_DATA = r.nvm_data;

endmodule // ictc_core

// ==== verif/ictc_props.sv ====
// Port checker of the coil timing capture sequencer
`timescale 1ns/10ps
module ictc_props
  import ictc_pkg::*;
(
  // Clock and reset
  input wire logic CLOCK,
  input wire logic SRST,
  // Requests and sensing
  input wire logic START,
  input wire logic PART_IS_RES,
  input wire logic [11:0] PART_RES,
  input wire logic NO_CUR_A,
  input wire logic NO_CUR_B,
  // Outputs
  input wire ictc_coil_type COIL,
  input wire ictc_result_type RESULT,
  input wire logic BUSY,
  input wire logic CAL_OK,
  input wire logic NVM_WE,
  input wire logic [2:0] NVM_ADDR
);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (SRST);
  logic go;
  assign go = !BUSY && START && PART_IS_RES && PART_RES < 12'd2100;
  chk_skip_part: assert property (!BUSY && START && !go |-> ##[1:2] RESULT.valid && RESULT.skipped)
    else $error("unsuitable part not skipped");
  chk_launch_fwd: assert property (go |=> BUSY && COIL.pos_high && !COIL.reverse)
    else $error("first run not launched forward");
  chk_sense_pick: assert property (go |=> COIL.sense_in == (PART_RES >= 12'd24))
    else $error("sense resistor choice wrong");
  chk_stop_discharge: assert property (BUSY && $fell(COIL.pos_high) |-> COIL.pos_low)
    else $error("coil not grounded after timing");
  chk_hold_low: assert property (COIL.pos_low && !(NO_CUR_A && NO_CUR_B) |=> COIL.pos_low)
    else $error("ground released while current remains");
  chk_no_short: assert property (!(COIL.pos_high && COIL.pos_low))
    else $error("terminal driven both ways");
  chk_nvm_burst: assert property ($rose(NVM_WE) |-> CAL_OK && NVM_ADDR == 3'h0 ##1 NVM_WE [*5] ##1 !NVM_WE)
    else $error("offset store burst wrong");
  chk_addr_step: assert property (NVM_WE && $past(NVM_WE) |-> NVM_ADDR == $past(NVM_ADDR) + 3'h1)
    else $error("offset store address skipped");
endmodule // ictc_props

bind ictc_core ictc_props i_props (.CLOCK, .SRST, .START, .PART_IS_RES, .PART_RES,
  .NO_CUR_A, .NO_CUR_B, .COIL, .RESULT, .BUSY, .CAL_OK, .NVM_WE, .NVM_ADDR);

// ==== verif/ictc_coil_model.sv ====
// Coil under test with its sense path
`timescale 1ns/10ps
module ictc_coil_model
  import ictc_pkg::*;
(
  // Drive from the sequencer
  input wire logic clock,
  input wire ictc_coil_type coil,
  // Trial behaviour
  input wire logic [15:0] rise0,
  input wire logic [15:0] rise1,
  input wire logic spike,
  // Sensed levels
  output logic cmp_above,
  output logic no_cur_a,
  output logic no_cur_b
);
  logic [16:0] k;
  logic [3:0] kl;
  logic [15:0] rise;
  always_ff @(posedge clock) begin
    k <= coil.pos_high ? k + 17'h1 : 17'h0;
    kl <= coil.pos_low ? kl + 4'(kl != 4'hf) : 4'h0;
  end
  // Own rise time per direction, so the direction choice shows
  assign rise = coil.reverse ? rise1 : rise0;
  // Parasitic spike trips the comparator in the first two cycles
  assign cmp_above = coil.pos_high && ((spike && k < 17'h2) || k >= {1'b0, rise});
  // Terminal B settles later, catching a one-terminal check
  assign no_cur_a = !coil.pos_high && (!coil.pos_low || kl >= 4'h3);
  assign no_cur_b = !coil.pos_high && (!coil.pos_low || kl >= 4'h5);
endmodule // ictc_coil_model

// ==== verif/ictc_core_test.sv ====
// Self-checking bench of the coil timing capture sequencer
`timescale 1ns/10ps
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin n_errors++; \
  $display("[FAIL] %s exp %0h got %0h", nm, e, g); end end
module ictc_core_test
  import ictc_pkg::*;
;
  logic clock, srst, start, cal_start, is_res, cmp, nca, ncb, spike, busy, cal_ok, nvm_we;
  logic seen_rev;
  logic [11:0] part_res;
  logic [15:0] rise0, rise1, nvm_data;
  logic [2:0] nvm_addr;
  logic [5:0][15:0] nvm_seen;
  ictc_cap_type cap_in, cap_out;
  ictc_coil_type coil;
  ictc_result_type result;
  int n_errors, checks, cyc;

  ictc_core i_dut (.CLOCK(clock), .SRST(srst), .START(start), .CAL_START(cal_start),
    .PART_IS_RES(is_res), .PART_RES(part_res), .LOG_INDEX(4'h0), .CMP_ABOVE(cmp),
    .NO_CUR_A(nca), .NO_CUR_B(ncb), .CAP_IN(cap_in), .COIL(coil), .RESULT(result),
    .BUSY(busy), .CAP_OUT(cap_out), .CAL_OK(cal_ok), .NVM_WE(nvm_we),
    .NVM_ADDR(nvm_addr), .NVM_DATA(nvm_data));
  ictc_coil_model i_coil (.clock(clock), .coil(coil), .rise0(rise0), .rise1(rise1),
    .spike(spike), .cmp_above(cmp), .no_cur_a(nca), .no_cur_b(ncb));

  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  always @(posedge clock) begin
    cyc++;
    if (nvm_we)
      nvm_seen[nvm_addr] <= nvm_data;
    if (coil.pos_high && coil.reverse)
      seen_rev <= 1'b1;
    if (cyc == 20000) begin
      n_errors++;
      tally_and_finish;
    end
  end

  task automatic step(int n);
    repeat (n) @(negedge clock);
  endtask

  // --------------------------------------------------------------
  // Expectations, table index fixed at 0 for a fine log step
  // --------------------------------------------------------------
  function automatic real exp_l(int cnt, int rg);
    return cnt * rg * (-1.0 / $ln(1.0 - 1.0 / 32)) / 200;
  endfunction

  function automatic logic near(logic [31:0] v, real e);
    real d;
    d = v - e;
    return (d < 0 ? -d : d) <= e / 200 + 2;
  endfunction

  task automatic run_l(logic [11:0] r, logic [15:0] a, logic [15:0] b, logic s, real e,
                       logic f);
    int n;
    part_res = r;
    rise0 = a;
    rise1 = b;
    spike = s;
    is_res = 1'b1;
    seen_rev = 1'b0;
    start = 1'b1;
    step(1);
    start = 1'b0;
    step(50);
    start = 1'b1;
    step(1);
    start = 1'b0;
    n = 0;
    while (result.valid !== 1'b1 && n < 9000) begin
      step(1);
      n++;
    end
    `CHK("res_fine", f, result.fine)
    `CHK("res_value", 1'b1, near(result.value, e))
    `CHK("both_dirs", 1'b1, seen_rev)
    if (!f)
      `CHK("res_tenth", 32'h0, result.value % 10)
    step(3);
    `CHK("busy_end", 1'b0, busy)
  endtask

  task automatic t_skip;
    for (int i = 0; i < 2; i++) begin
      is_res = i[0];
      part_res = i ? 12'd2100 : 12'd5;
      start = 1'b1;
      step(1);
      start = 1'b0;
      if (result.valid !== 1'b1)
        step(1);
      `CHK("skip_flag", 1'b1, result.valid && result.skipped)
      `CHK("skip_busy", 1'b0, busy)
      step(1);
    end
    $display("test skip done");
  endtask

  task automatic t_fine;
    // Rise ends inside the delay, so delayed runs read zero and the fine run wins
    run_l(12'd10, 16'd90, 16'd90, 1'b0, exp_l(84, 29), 1'b1);
    $display("test fine done");
  endtask

  task automatic t_coarse;
    run_l(12'd2099, 16'd310, 16'd400, 1'b0, exp_l(303, 2798), 1'b0);
    $display("test coarse done");
  endtask

  task automatic t_spike;
    run_l(12'd10, 16'd1100, 16'd1100, 1'b1, exp_l(993, 709), 1'b0);
    $display("test spike done");
  endtask

  task automatic t_cal;
    cal_start = 1'b1;
    step(1);
    cal_start = 1'b0;
    cap_in = '{1'b1, 3'd6, 16'hffff};
    step(1);
    for (int j = 0; j < 8; j++)
      for (int c = 0; c < 6; c++) begin
        cap_in = '{1'b1, 3'(c), 16'(16 * c + j)};
        step(1);
      end
    cap_in.valid = 1'b0;
    step(12);
    `CHK("cal_ok", 1'b1, cal_ok)
    for (int c = 0; c < 6; c++)
      `CHK("offset", 16'(16 * c + 3), nvm_seen[c])
    // Second stage: a capacitor on probes one and three reads as combination 2
    cap_in = '{1'b1, 3'd2, 16'd500};
    step(1);
    cap_in.valid = 1'b0;
    `CHK("cap_valid", 1'b1, cap_out.valid)
    `CHK("cap_corr", 16'd465, cap_out.value)
    $display("test cal done");
  endtask

  task automatic tally_and_finish;
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  initial begin
    srst = 1'b1;
    {start, cal_start, is_res, spike, seen_rev} = '0;
    {part_res, rise0, rise1, cap_in, nvm_seen} = '0;
    step(4);
    srst = 1'b0;
    t_skip;
    t_fine;
    t_coarse;
    t_spike;
    t_cal;
    tally_and_finish;
  end
endmodule // ictc_core_test
